// [src/itop_defines.vh]
// Operation
// - global output holds 7-bit RAM data [22:16]
// - RAM data active only RAM mode, control-unit
// - stage-2-only maps to word bits 97:91
// - full translation maps to word bits 129:123
// - direction bit picks RAM read or write
// - bit 9 drives secure global fault irq
// - bit 1 drives nonsecure global fault irq
// - RAM mode zero: index is interrupt control
// - control-unit RAM mode: index gives way/index
// - buffer-unit RAM mode: index gives RAM index
// - index bit n drives unit n perf irq
// - control bit 0 selects integration mode
// - control bit 1 RAM mode, resets zero
// - control bit 2: zero reads, one writes
// - control bit 3: control or buffer unit
`ifndef ITOP_DEFINES_VH
`define ITOP_DEFINES_VH

// register byte offsets
`define ITOP_CTRL_ADDR 12'h000
`define ITOP_GLBL_ADDR 12'h004
`define ITOP_INDEX_ADDR 12'h008
`define ITOP_STAT_ADDR 12'h00c
`define ITOP_MASK_ADDR 12'h010

// integration control fields
`define ITOP_CTRL_INTG 0
`define ITOP_CTRL_RAM 1
`define ITOP_CTRL_DIR 2
`define ITOP_CTRL_MOD 3
`define ITOP_CTRL_ACC_HI 8
`define ITOP_CTRL_ACC_LO 4
`define ITOP_CTRL_MASK 32'h000001ff

// global output fields
`define ITOP_GLBL_DATA_HI 22
`define ITOP_GLBL_DATA_LO 16
`define ITOP_GLBL_SFI 9
`define ITOP_GLBL_NSFI 1

// RAM word geometry
`define ITOP_WORD_S2_TOP 97
`define ITOP_WORD_FULL_TOP 129

// status bits
`define ITOP_STAT_RD 0
`define ITOP_STAT_WR 1
`define ITOP_STAT_W 2

// reset values
`define ITOP_RST_ZERO 32'h00000000

`endif

// [src/integration_test_output_regs.v]
// Our own choices: the APB slave port and the register addresses.
`include "itop_defines.vh"
`default_nettype none

module integration_test_output_regs #(
    parameter NUM_UNITS = 32,
    parameter NESTED = 1,
    parameter WORD_W = 130
)(
    input wire clk_sys_in,
    input wire rst_in,
    input wire ce_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire ram_rvalid_in,
    input wire [WORD_W-1:0] ram_rdata_in,
    output reg ram_req_out,
    output reg ram_write_out,
    output reg ram_unit_sel_out,
    output reg [4:0] ram_access_out,
    output reg [31:0] ram_index_out,
    output reg [WORD_W-1:0] ram_wdata_out,
    output reg secure_global_fault_irq_out,
    output reg nonsecure_global_fault_irq_out,
    output reg [NUM_UNITS-1:0] perf_irq_out,
    output reg irq_out
);

    // top bit of the data field in the selected RAM word
    localparam TOP = NESTED ? `ITOP_WORD_FULL_TOP : `ITOP_WORD_S2_TOP;
    // data field width, fixed at seven bits in every configuration
    localparam FW = `ITOP_GLBL_DATA_HI - `ITOP_GLBL_DATA_LO + 1;
    localparam SW = `ITOP_STAT_W;

    // access sequencer states
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;

    // software-visible state and sequencer
    reg [8:0] integration_control;
    reg [FW-1:0] control_unit_ram_top_bits;
    reg global_secure_fault_irq_drive;
    reg global_nonsecure_fault_irq_drive;
    reg [31:0] integration_perf_interrupt_index;
    reg [SW-1:0] irq_status;
    reg [SW-1:0] irq_mask;
    reg [1:0] state;

    // decoded control fields and bus qualifiers
    wire integration_mode_enable;
    wire ram_mode;
    wire ram_dir_write;
    wire ram_module;
    wire cu_ram_sel;
    wire access;
    wire wr_en;
    wire rd_en;
    wire launch;
    wire read_done;
    wire write_done;
    wire [SW-1:0] events;
    wire [SW-1:0] next_status;
    wire [NUM_UNITS-1:0] next_perf;
    reg [31:0] rd_mux;
    reg rd_hit;

    // register address hits
    wire hit_ctrl;
    wire hit_glbl;
    wire hit_index;
    wire hit_stat;
    wire hit_mask;

    // control fields decoded once for the rest of the block
    assign integration_mode_enable = integration_control[`ITOP_CTRL_INTG];
    assign ram_mode = integration_control[`ITOP_CTRL_RAM];
    assign ram_dir_write = integration_control[`ITOP_CTRL_DIR];
    assign ram_module = integration_control[`ITOP_CTRL_MOD];
    assign cu_ram_sel = ram_mode & ~ram_module;

    // one decode per register, used by the control, global, index and mask writes
    assign hit_ctrl = (paddr_in == `ITOP_CTRL_ADDR);
    assign hit_glbl = (paddr_in == `ITOP_GLBL_ADDR);
    assign hit_index = (paddr_in == `ITOP_INDEX_ADDR);
    assign hit_stat = (paddr_in == `ITOP_STAT_ADDR);
    assign hit_mask = (paddr_in == `ITOP_MASK_ADDR);

    // access phase completes on the cycle pready is raised
    assign access = psel_in & penable_in & ~pready_out;
    assign wr_en = ce_in & access & pwrite_in;
    assign rd_en = ce_in & access & ~pwrite_in;

    // a RAM test access starts on a write to the index register
    assign launch = wr_en & hit_index & ram_mode & integration_mode_enable
        & (state == ST_IDLE);
    assign read_done = (state == ST_WAIT) & ram_rvalid_in & ~ram_write_out;
    assign write_done = (state == ST_WAIT) & ram_write_out;
    assign events = {write_done, read_done};

    // set wins over a software clear in the same cycle
    assign next_status = (wr_en && paddr_in == `ITOP_STAT_ADDR) ?
        ((irq_status & ~pwdata_in[SW-1:0]) | events) : (irq_status | events);

    // interrupt layout only outside RAM mode
    assign next_perf = (integration_mode_enable & ~ram_mode) ?
        integration_perf_interrupt_index[NUM_UNITS-1:0] : {NUM_UNITS{1'b0}};

    // read mux, reserved bits forced to zero
    always @*
    begin
        rd_mux = `ITOP_RST_ZERO;
        rd_hit = 1'b1;
        case (paddr_in)
            `ITOP_CTRL_ADDR:
                rd_mux[8:0] = integration_control;
            `ITOP_GLBL_ADDR:
            begin
                rd_mux[`ITOP_GLBL_DATA_HI:`ITOP_GLBL_DATA_LO] = control_unit_ram_top_bits;
                rd_mux[`ITOP_GLBL_SFI] = global_secure_fault_irq_drive;
                rd_mux[`ITOP_GLBL_NSFI] = global_nonsecure_fault_irq_drive;
            end
            `ITOP_INDEX_ADDR:
                rd_mux = integration_perf_interrupt_index;
            `ITOP_STAT_ADDR:
                rd_mux[SW-1:0] = irq_status;
            `ITOP_MASK_ADDR:
                rd_mux[SW-1:0] = irq_mask;
            default:
                rd_hit = 1'b0;
        endcase
    end

    // apb answer: one wait state, pready in the second access cycle
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else if (ce_in)
        begin
            pready_out <= access;
            pslverr_out <= access & ~rd_hit;
        end
    end

    // read data holds until the next read, so a late sampler still sees it
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_out <= 32'h00000000;
        end
        else if (ce_in && rd_en)
        begin
            prdata_out <= rd_mux;
        end
    end

    // integration control; bits above 8 are reserved and dropped
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            integration_control <= 9'h000;
        end
        else if (wr_en && hit_ctrl)
        begin
            integration_control <= pwdata_in[8:0];
        end
    end

    // global fault drives; they reach the pins only in integration mode
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            global_secure_fault_irq_drive <= 1'b0;
            global_nonsecure_fault_irq_drive <= 1'b0;
        end
        else if (wr_en && hit_glbl)
        begin
            global_secure_fault_irq_drive <= pwdata_in[`ITOP_GLBL_SFI];
            global_nonsecure_fault_irq_drive <= pwdata_in[`ITOP_GLBL_NSFI];
        end
    end

    // index word; its meaning depends on the RAM mode and module bits
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            integration_perf_interrupt_index <= 32'h00000000;
        end
        else if (wr_en && hit_index)
        begin
            integration_perf_interrupt_index <= pwdata_in;
        end
    end

    // interrupt mask, same layout as the status register
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_mask <= {SW{1'b0}};
        end
        else if (wr_en && hit_mask)
        begin
            irq_mask <= pwdata_in[SW-1:0];
        end
    end

    // data field: software write, or load from a finished RAM read
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            control_unit_ram_top_bits <= {FW{1'b0}};
        end
        else if (ce_in)
        begin
            if (read_done && !ram_unit_sel_out)
            begin
                control_unit_ram_top_bits <= ram_rdata_in[TOP:TOP-FW+1];
            end
            else if (wr_en && paddr_in == `ITOP_GLBL_ADDR)
            begin
                control_unit_ram_top_bits <= pwdata_in[`ITOP_GLBL_DATA_HI:`ITOP_GLBL_DATA_LO];
            end
        end
    end

    // RAM test access sequencer; a write completes in one cycle,
    // a read waits for ram_rvalid_in with no timeout
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ST_IDLE;
            ram_req_out <= 1'b0;
            ram_write_out <= 1'b0;
            ram_unit_sel_out <= 1'b0;
            ram_access_out <= 5'h00;
            ram_index_out <= 32'h00000000;
            ram_wdata_out <= {WORD_W{1'b0}};
        end
        else if (ce_in)
        begin
            case (state)
                ST_IDLE:
                begin
                    ram_req_out <= 1'b0;
                    if (launch)
                    begin
                        state <= ST_WAIT;
                        ram_req_out <= 1'b1;
                        ram_write_out <= ram_dir_write;
                        ram_unit_sel_out <= ram_module;
                        ram_access_out <= integration_control[`ITOP_CTRL_ACC_HI:`ITOP_CTRL_ACC_LO];
                        ram_index_out <= pwdata_in;
                        ram_wdata_out <= {WORD_W{1'b0}};
                        if (cu_ram_sel)
                        begin
                            // only the top bits are reachable from here
                            ram_wdata_out[TOP:TOP-FW+1] <= control_unit_ram_top_bits;
                        end
                    end
                end
                ST_WAIT:
                begin
                    ram_req_out <= 1'b0;
                    if (write_done || read_done)
                    begin
                        state <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // sticky status; a same-cycle clear loses to the event
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_status <= {SW{1'b0}};
        end
        else if (ce_in)
        begin
            irq_status <= next_status;
        end
    end

    // level interrupt from next_status, so it rises with the status bit
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_out <= 1'b0;
        end
        else if (ce_in)
        begin
            irq_out <= |(next_status & irq_mask);
        end
    end

    // global fault pins, forced low outside integration mode
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            secure_global_fault_irq_out <= 1'b0;
            nonsecure_global_fault_irq_out <= 1'b0;
        end
        else if (ce_in)
        begin
            secure_global_fault_irq_out <= integration_mode_enable & global_secure_fault_irq_drive;
            nonsecure_global_fault_irq_out <= integration_mode_enable & global_nonsecure_fault_irq_drive;
        end
    end

    // per-unit perf pins, registered to keep outputs glitch free
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            perf_irq_out <= {NUM_UNITS{1'b0}};
        end
        else if (ce_in)
        begin
            perf_irq_out <= next_perf;
        end
    end

endmodule

`default_nettype wire

// [verif/itop_props.sv]
`default_nettype none
module itop_props #(
    parameter NUM_UNITS = 32,
    parameter NESTED = 1,
    parameter WORD_W = 130
)(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic ram_rvalid_in,
    input wire logic [WORD_W-1:0] ram_rdata_in,
    input wire logic ram_req_out,
    input wire logic ram_write_out,
    input wire logic ram_unit_sel_out,
    input wire logic [WORD_W-1:0] ram_wdata_out,
    input wire logic secure_global_fault_irq_out,
    input wire logic nonsecure_global_fault_irq_out,
    input wire logic [NUM_UNITS-1:0] perf_irq_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    localparam int TOP = NESTED ? 129 : 97;
    logic [31:0] ctl, glb, idx;
    logic busy;
    // pending RAM access and the read loads of the data field it causes
    wire pend = busy || ram_req_out;
    wire done = pend && ce_in && (ram_write_out || ram_rvalid_in);
    wire load = done && !ram_write_out && !ram_unit_sel_out;
    wire wr = psel_in && penable_in && !pready_out && ce_in && pwrite_in;
    wire mapped = paddr_in inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    // shadow of software writes; a read load overrides a same-cycle write
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctl <= 32'h0;
            glb <= 32'h0;
            idx <= 32'h0;
            busy <= 1'b0;
        end
        else
        begin
            busy <= pend && !done;
            if (wr && paddr_in == 12'h000)
                ctl <= pwdata_in & 32'h000001ff;
            if (wr && paddr_in == 12'h004)
                glb <= pwdata_in;
            if (wr && paddr_in == 12'h008)
                idx <= pwdata_in;
            if (load)
                glb[22:16] <= ram_rdata_in[TOP -: 7];
        end
    end
    a_ready_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
        else $error("pready timing wrong");
    a_unmapped_err: assert property (pready_out |-> pslverr_out == !mapped
        && (!pslverr_out || pwrite_in || prdata_out == 32'h0)) else $error("unmapped answer wrong");
    a_secure_drive: assert property (secure_global_fault_irq_out == $past(ctl[0] && glb[9]))
        else $error("secure fault irq wrong");
    a_nonsec_drive: assert property (nonsecure_global_fault_irq_out == $past(ctl[0] && glb[1]))
        else $error("nonsecure fault irq wrong");
    a_perf_drive: assert property (perf_irq_out == ($past(ctl[1:0] == 2'b01) ?
        $past(idx[NUM_UNITS-1:0]) : {NUM_UNITS{1'b0}})) else $error("perf irq wrong");
    a_launch_cause: assert property (ram_req_out |-> $past(wr && paddr_in == 12'h008 && ctl[1:0] == 2'b11)
        ##1 !ram_req_out) else $error("ram request wrong");
    a_dir_module: assert property (ram_req_out |-> ram_write_out == $past(ctl[2])
        && ram_unit_sel_out == $past(ctl[3])) else $error("ram direction or module wrong");
    a_wdata_top: assert property (ram_req_out && ram_write_out && !ram_unit_sel_out |->
        ram_wdata_out == ({{(WORD_W-7){1'b0}}, $past(glb[22:16])} << (TOP-6)))
        else $error("ram write word wrong");
    cover property (ram_req_out && ram_write_out);
    cover property (ram_req_out && ram_unit_sel_out);
    cover property (secure_global_fault_irq_out && nonsecure_global_fault_irq_out);
endmodule
bind integration_test_output_regs itop_props #(.NUM_UNITS(NUM_UNITS), .NESTED(NESTED), .WORD_W(WORD_W))
    itop_props_i (.*);
`default_nettype wire

// [verif/integration_test_output_regs_tb.sv]
`default_nettype none
module integration_test_output_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam W = 130;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rvalid = 1'b0, ce = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, r;
    logic [W-1:0] rdata = {W{1'b0}};
    logic [33:0] x;
    logic [33:0] q[$];
    wire [31:0] prdata, idx, perf;
    wire pready, perr, req, rwr, usel, sfi, nsfi, irq;
    wire [4:0] acc;
    wire [W-1:0] wdata;
    int err_total = 0, tests_run = 0;
    integration_test_output_regs #(.NUM_UNITS(32), .NESTED(1), .WORD_W(W)) integration_test_output_regs_i (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(perr), .ram_rvalid_in(rvalid), .ram_rdata_in(rdata), .ram_req_out(req),
        .ram_write_out(rwr), .ram_unit_sel_out(usel), .ram_access_out(acc), .ram_index_out(idx),
        .ram_wdata_out(wdata), .secure_global_fault_irq_out(sfi), .nonsecure_global_fault_irq_out(nsfi),
        .perf_irq_out(perf), .irq_out(irq));
    initial
    begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task give_verdict;
        $display("mismatches %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one transfer; x holds {compare data, expected error, expected data}
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        logic done;
        q.push_back(e);
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        pen <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 20 && !done; n++)
        begin
            @(posedge clk_sys_in);
            done = (pready === 1'b1);
        end
        if (!done)
        begin
            err_total++;
            give_verdict();
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {2'b10, e});
    endtask
    task st;
        repeat (2) @(posedge clk_sys_in);
    endtask
    // read word pulse; bus shows inverted junk once released
    task rv(input logic [6:0] v);
        @(posedge clk_sys_in);
        rvalid <= 1'b1;
        rdata <= {v, {(W-7){1'b0}}};
        @(posedge clk_sys_in);
        rvalid <= 1'b0;
        rdata <= ~{v, {(W-7){1'b0}}};
    endtask
    // answer checker: oldest note against each pready
    always @(posedge clk_sys_in)
    begin
        if (pready === 1'b1)
        begin
            x = q.pop_front();
            chk("slverr", 32'(perr), 32'(x[32]));
            if (x[33])
                chk("prdata", prdata, x[31:0]);
        end
    end
    initial
    begin
        r = $urandom(32'h6f0aeb4e);
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 24; a += 4)
            apb(1'b0, 12'(a), 32'h0, {1'b1, a > 16, 32'h0});
        apb(1'b1, 12'h020, 32'hffffffff, 34'h100000000);
        wr(12'h000, 32'hffffffff);
        rd(12'h000, 32'h000001ff);
        r = $urandom;
        wr(12'h004, r);
        rd(12'h004, r & 32'h007f0202);
        $display("register test done");
        for (int k = 0; k < 8; k++)
        begin
            wr(12'h000, {31'h0, k[2]});
            wr(12'h004, {22'h0, k[1], 7'h0, k[0], 1'b0});
            st();
            chk("sfi", 32'(sfi), 32'(k[2] & k[1]));
            chk("nsfi", 32'(nsfi), 32'(k[2] & k[0]));
        end
        r = $urandom;
        wr(12'h000, 32'h1);
        wr(12'h008, r);
        st();
        chk("perf", perf, r);
        wr(12'h000, 32'h3);
        st();
        chk("perf ram", perf, 32'h0);
        rd(12'h008, r);
        $display("irq drive test done");
        wr(12'h010, 32'h1);
        wr(12'h000, 32'h7);
        wr(12'h004, 32'h005a0000);
        wr(12'h008, r);
        st();
        chk("dir", 32'(rwr), 32'h1);
        chk("index", idx, r);
        chk("wtop", 32'(wdata[W-1 -: 7]), 32'h5a);
        chk("masked", 32'(irq), 32'h0);
        rd(12'h00c, 32'h2);
        wr(12'h010, 32'h3);
        st();
        chk("irq", 32'(irq), 32'h1);
        wr(12'h00c, 32'h2);
        st();
        chk("cleared", 32'(irq), 32'h0);
        wr(12'h000, 32'h3);
        wr(12'h008, r);
        // clock enable low: a read answer in that time must not land
        @(posedge clk_sys_in);
        ce <= 1'b0;
        rv(7'h44);
        @(posedge clk_sys_in);
        ce <= 1'b1;
        rd(12'h00c, 32'h0);
        rd(12'h004, 32'h005a0000);
        rv(7'h33);
        rd(12'h004, 32'h00330000);
        rd(12'h00c, 32'h1);
        $display("unit ram test done");
        wr(12'h000, 32'h1fb);
        wr(12'h008, 32'h7f);
        rv(7'h11);
        st();
        chk("sel", 32'(usel), 32'h1);
        chk("access", 32'(acc), 32'h1f);
        rd(12'h004, 32'h00330000);
        $display("buffer ram test done");
        give_verdict();
    end
endmodule
`default_nettype wire
